//--- shared/vpc_pkg.sv
// Constants for the vector processor control register block
package vpc_pkg;
    localparam int VL_W = 7;
    localparam logic [6:0] VL_MAX = 7'h40;
    localparam logic [6:0] VL_RST = 7'h00;
    localparam logic [63:0] RTC_RST = 64'h0000_0000_0000_0000;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    // Opcode f field values
    localparam logic [6:0] OP_JCS = 7'h04;
    localparam logic [6:0] OP_JSS = 7'h05;
    localparam logic [6:0] OP_SSM = 7'h06;
    localparam logic [6:0] OP_CSM = 7'h07;
    localparam logic [6:0] OP_VL_TO_A = 7'h15;
    localparam logic [6:0] OP_MASK_LO = 7'h18;
    localparam logic [6:0] OP_MASK_HI = 7'h1b;
    localparam logic [6:0] OP_S_TO_RTC = 7'h1d;
    localparam logic [6:0] OP_A_TO_VL = 7'h1e;
    localparam logic [6:0] OP_RTC_TO_S = 7'h4d;
    // Foreground register selectors
    localparam logic [2:0] SEL_VL = 3'h0;
    localparam logic [2:0] SEL_RTC_LO = 3'h1;
    localparam logic [2:0] SEL_RTC_HI = 3'h2;
    localparam logic [2:0] SEL_BASE = 3'h3;
    localparam logic [2:0] SEL_LIMIT = 3'h4;
    localparam logic [2:0] SEL_PROG = 3'h5;
    localparam logic [2:0] SEL_STATUS = 3'h6;
    // Status register fields
    localparam int ST_SEM_LSB = 0;
    localparam int ST_SEM_W = 5;
    localparam int ST_RD_ERR = 13;
    localparam int ST_WR_ERR = 14;
    typedef enum logic [1:0] {
        VPC_IDLE = 2'b00,
        VPC_RUN = 2'b01,
        VPC_NOP = 2'b11
    } vpc_state_t;
endpackage

//--- hdl/vpc_regs.sv
// Control registers, issue logic and memory relocation of a vector processor
module vpc_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic proc_idle,
    input wire logic monitor_mode,
    input wire logic fg_wr,
    input wire logic fg_sem_wr,
    input wire logic [2:0] fg_sel,
    input wire logic [31:0] fg_wdata,
    output logic [31:0] fg_rdata,
    input wire logic ins_valid,
    output logic ins_ready,
    input wire logic [6:0] ins_op,
    input wire logic ins_vec,
    input wire logic [1:0] ins_parcels,
    input wire logic ins_jump,
    input wire logic [31:0] ins_target,
    input wire logic [31:0] ins_ak,
    input wire logic [63:0] ins_sj,
    output logic [6:0] vl_out,
    output logic [63:0] rtc_out,
    output logic [31:0] prog_addr,
    output logic vec_noop,
    output logic elem_valid,
    output logic [5:0] elem_idx,
    output logic vec_done,
    input wire logic [31:0] sem_flags,
    input wire logic mem_quiet,
    output logic [4:0] sem_sel,
    output logic sem_set,
    output logic sem_clr,
    input wire logic ref_valid,
    input wire logic ref_write,
    input wire logic [31:0] ref_addr,
    input wire logic [63:0] ref_wdata,
    output logic ref_rvalid,
    output logic [63:0] ref_rdata,
    output logic mem_valid,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [63:0] mem_wdata,
    input wire logic mem_rvalid,
    input wire logic [63:0] mem_rdata,
    output logic [31:0] status
);
    ////////////////////////////////////////////////////////////////////////
    logic [6:0] vl_q;
    logic [63:0] rtc_q;
    logic [31:0] base_q;
    logic [31:0] limit_q;
    logic [31:0] prog_q;
    logic [4:0] sem_ptr_q;
    logic rd_err_q;
    logic wr_err_q;
    logic [6:0] vl_out_q;
    logic [63:0] rtc_out_q;
    logic [6:0] len_q;
    logic [5:0] idx_q;
    logic noop_q;
    logic done_q;
    logic set_q;
    logic clr_q;
    logic clr_pend_q;
    logic [31:0] fg_rdata_q;
    logic mem_valid_q;
    logic mem_write_q;
    logic [31:0] mem_addr_q;
    logic [63:0] mem_wdata_q;
    logic oor_rd_q;
    logic ref_rvalid_q;
    logic [63:0] ref_rdata_q;
    vpc_pkg::vpc_state_t state_q;
    logic take;
    logic is_mask_op;
    logic [6:0] eff_len;
    logic flag_now;
    logic jump_taken;
    logic [31:0] abs_addr;
    logic oor;
    logic fg_idle_wr;
    ////////////////////////////////////////////////////////////////////////
    // Issue and decode
    assign ins_ready = (state_q == vpc_pkg::VPC_IDLE) && !proc_idle;
    assign take = ins_valid && ins_ready;
    assign is_mask_op = (ins_op >= vpc_pkg::OP_MASK_LO) &&
                        (ins_op <= vpc_pkg::OP_MASK_HI);
    assign eff_len = (vl_q > vpc_pkg::VL_MAX) ? vpc_pkg::VL_MAX : vl_q;
    assign flag_now = sem_flags[sem_ptr_q];
    always_comb begin
        case (ins_op)
            vpc_pkg::OP_JCS: jump_taken = !flag_now;
            vpc_pkg::OP_JSS: jump_taken = flag_now;
            default: jump_taken = ins_jump;
        endcase
    end
    assign fg_idle_wr = fg_wr && proc_idle;
    ////////////////////////////////////////////////////////////////////////
    // Vector length register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vl_q <= vpc_pkg::VL_RST;
            vl_out_q <= vpc_pkg::VL_RST;
        end else begin
            if (take && ins_op == vpc_pkg::OP_A_TO_VL) begin
                vl_q <= ins_ak[6:0];
            end else if (fg_idle_wr && fg_sel == vpc_pkg::SEL_VL) begin
                vl_q <= fg_wdata[6:0];
            end
            if (take && ins_op == vpc_pkg::OP_VL_TO_A) begin
                vl_out_q <= vl_q;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Real-time counter, cleared at deadstart
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rtc_q <= vpc_pkg::RTC_RST;
            rtc_out_q <= vpc_pkg::RTC_RST;
        end else begin
            if (take && ins_op == vpc_pkg::OP_S_TO_RTC && monitor_mode) begin
                rtc_q <= {ins_sj[63:2], 2'b00};
            end else begin
                rtc_q <= rtc_q + 64'h0000_0000_0000_0001;
            end
            if (take && ins_op == vpc_pkg::OP_RTC_TO_S) begin
                rtc_out_q <= rtc_q;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Base, limit and program address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_q <= vpc_pkg::ADDR_RST;
            limit_q <= vpc_pkg::ADDR_RST;
        end else if (fg_idle_wr) begin
            if (fg_sel == vpc_pkg::SEL_BASE) begin
                base_q <= fg_wdata;
            end
            if (fg_sel == vpc_pkg::SEL_LIMIT) begin
                limit_q <= fg_wdata;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_q <= vpc_pkg::ADDR_RST;
        end else if (fg_idle_wr && fg_sel == vpc_pkg::SEL_PROG) begin
            prog_q <= fg_wdata;
        end else if (take) begin
            if (jump_taken) begin
                prog_q <= ins_target;
            end else begin
                prog_q <= prog_q + 32'h0000_0001 + {30'h0000_0000, ins_parcels};
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Vector sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= vpc_pkg::VPC_IDLE;
            len_q <= vpc_pkg::VL_RST;
            idx_q <= 6'h00;
            noop_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            noop_q <= 1'b0;
            done_q <= 1'b0;
            case (state_q)
                vpc_pkg::VPC_IDLE: begin
                    idx_q <= 6'h00;
                    if (take && ins_vec) begin
                        len_q <= eff_len;
                        if (eff_len == 7'h00 && !is_mask_op) begin
                            state_q <= vpc_pkg::VPC_NOP;
                        end else if (eff_len == 7'h00) begin
                            done_q <= 1'b1;
                        end else begin
                            state_q <= vpc_pkg::VPC_RUN;
                        end
                    end
                end
                vpc_pkg::VPC_RUN: begin
                    if ({1'b0, idx_q} == len_q - 7'h01) begin
                        state_q <= vpc_pkg::VPC_IDLE;
                        done_q <= 1'b1;
                    end else begin
                        idx_q <= idx_q + 6'h01;
                    end
                end
                vpc_pkg::VPC_NOP: begin
                    noop_q <= 1'b1;
                    state_q <= vpc_pkg::VPC_IDLE;
                end
                default: state_q <= vpc_pkg::VPC_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Semaphore flags and status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sem_ptr_q <= 5'h00;
            set_q <= 1'b0;
            clr_q <= 1'b0;
            clr_pend_q <= 1'b0;
        end else begin
            if (fg_sem_wr) begin
                sem_ptr_q <= fg_wdata[4:0];
            end
            set_q <= take && (ins_op == vpc_pkg::OP_JCS ||
                     ins_op == vpc_pkg::OP_JSS || ins_op == vpc_pkg::OP_SSM);
            clr_q <= clr_pend_q && mem_quiet;
            if (take && ins_op == vpc_pkg::OP_CSM) begin
                clr_pend_q <= 1'b1;
            end else if (mem_quiet) begin
                clr_pend_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_err_q <= 1'b0;
            wr_err_q <= 1'b0;
        end else begin
            // Set wins over a foreground clear
            rd_err_q <= (ref_valid && !ref_write && oor) ||
                (rd_err_q && !(fg_wr && fg_sel == vpc_pkg::SEL_STATUS &&
                 !fg_wdata[vpc_pkg::ST_RD_ERR]));
            wr_err_q <= (ref_valid && ref_write && oor) ||
                (wr_err_q && !(fg_wr && fg_sel == vpc_pkg::SEL_STATUS &&
                 !fg_wdata[vpc_pkg::ST_WR_ERR]));
        end
    end
    always_comb begin
        status = 32'h0000_0000;
        status[vpc_pkg::ST_SEM_LSB +: vpc_pkg::ST_SEM_W] = sem_ptr_q;
        status[vpc_pkg::ST_RD_ERR] = rd_err_q;
        status[vpc_pkg::ST_WR_ERR] = wr_err_q;
    end
    ////////////////////////////////////////////////////////////////////////
    // Memory relocation and limit check
    assign abs_addr = ref_addr + base_q;
    assign oor = abs_addr >= limit_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_valid_q <= 1'b0;
            mem_write_q <= 1'b0;
            mem_addr_q <= vpc_pkg::ADDR_RST;
            mem_wdata_q <= 64'h0000_0000_0000_0000;
            oor_rd_q <= 1'b0;
            ref_rvalid_q <= 1'b0;
            ref_rdata_q <= 64'h0000_0000_0000_0000;
        end else begin
            mem_valid_q <= ref_valid && !oor;
            mem_write_q <= ref_valid && ref_write && !oor;
            mem_addr_q <= abs_addr;
            mem_wdata_q <= ref_wdata;
            oor_rd_q <= ref_valid && !ref_write && oor;
            ref_rvalid_q <= mem_rvalid || oor_rd_q;
            if (mem_rvalid) begin
                ref_rdata_q <= mem_rdata;
            end else begin
                ref_rdata_q <= 64'h0000_0000_0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Foreground read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fg_rdata_q <= 32'h0000_0000;
        end else begin
            case (fg_sel)
                vpc_pkg::SEL_VL: fg_rdata_q <= {25'h000_0000, vl_q};
                vpc_pkg::SEL_RTC_LO: fg_rdata_q <= rtc_q[31:0];
                vpc_pkg::SEL_RTC_HI: fg_rdata_q <= rtc_q[63:32];
                vpc_pkg::SEL_BASE: fg_rdata_q <= base_q;
                vpc_pkg::SEL_LIMIT: fg_rdata_q <= limit_q;
                vpc_pkg::SEL_PROG: fg_rdata_q <= prog_q;
                vpc_pkg::SEL_STATUS: fg_rdata_q <= status;
                default: fg_rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign fg_rdata = fg_rdata_q;
    assign vl_out = vl_out_q;
    assign rtc_out = rtc_out_q;
    assign prog_addr = prog_q;
    assign vec_noop = noop_q;
    assign elem_valid = (state_q == vpc_pkg::VPC_RUN);
    assign elem_idx = idx_q;
    assign vec_done = done_q;
    assign sem_sel = sem_ptr_q;
    assign sem_set = set_q;
    assign sem_clr = clr_q;
    assign ref_rvalid = ref_rvalid_q;
    assign ref_rdata = ref_rdata_q;
    assign mem_valid = mem_valid_q;
    assign mem_write = mem_write_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_zero_issue;
        take && ins_vec && eff_len == 7'h00 && !is_mask_op;
    endsequence
    sequence s_noop_step;
        state_q == vpc_pkg::VPC_NOP ##1 vec_noop;
    endsequence
    property p_noop;
        s_zero_issue |=> s_noop_step;
    endproperty
    a_noop: assert property (p_noop) else $error("no-op step wrong");
    property p_rtc_inc;
        !(take && ins_op == vpc_pkg::OP_S_TO_RTC && monitor_mode)
            |=> rtc_q == $past(rtc_q) + 64'h0000_0000_0000_0001;
    endproperty
    a_rtc_inc: assert property (p_rtc_inc) else $error("rtc stall");
    property p_rtc_load;
        take && ins_op == vpc_pkg::OP_S_TO_RTC && monitor_mode
            |=> rtc_q == {$past(ins_sj[63:2]), 2'b00};
    endproperty
    a_rtc_load: assert property (p_rtc_load) else $error("rtc load");
    property p_vl_load;
        take && ins_op == vpc_pkg::OP_A_TO_VL |=> vl_q == $past(ins_ak[6:0]);
    endproperty
    a_vl_load: assert property (p_vl_load) else $error("vl load");
    property p_clamp;
        state_q == vpc_pkg::VPC_RUN |-> len_q <= vpc_pkg::VL_MAX && idx_q < len_q;
    endproperty
    a_clamp: assert property (p_clamp) else $error("length clamp");
    property p_base_hold;
        !proc_idle |=> $stable(base_q) && $stable(limit_q);
    endproperty
    a_base_hold: assert property (p_base_hold) else $error("base moved");
    property p_oor;
        ref_valid && oor |=> !mem_valid && (rd_err_q || wr_err_q);
    endproperty
    a_oor: assert property (p_oor) else $error("range error");
    property p_reloc;
        ref_valid && !oor |=> mem_valid && mem_addr == $past(abs_addr);
    endproperty
    a_reloc: assert property (p_reloc) else $error("relocation");
    property p_seq_elem;
        take && ins_vec && eff_len != 7'h00
            |=> elem_valid && elem_idx == 6'h00 ##1 elem_idx <= 6'h01;
    endproperty
    a_seq_elem: assert property (p_seq_elem) else $error("element order");
    property p_pc_step;
        take && !jump_taken && !fg_idle_wr
            |=> prog_q == $past(prog_q) + 32'h0000_0001
                + {30'h0000_0000, $past(ins_parcels)};
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc step");
endmodule

//--- verif/vpc_fg_model.sv
// Foreground processor model: loads and reads the control registers
module vpc_fg_model (
    input wire logic clk,
    output logic proc_idle,
    output logic fg_wr,
    output logic fg_sem_wr,
    output logic [2:0] fg_sel,
    output logic [31:0] fg_wdata,
    input wire logic [31:0] fg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        proc_idle = 1'h1;
        fg_wr = 1'h0;
        fg_sem_wr = 1'h0;
        fg_sel = 3'h0;
        fg_wdata = 32'h0000_0000;
    end
    ////////////////////////////////////////////////////////////////////
    // Loads of base, limit and program address only while idle is high
    task automatic set_idle(input logic v);
        proc_idle <= v;
        @(posedge clk);
    endtask
    task automatic fg_write(input logic [2:0] s, input logic [31:0] d);
        fg_wr <= 1'h1;
        fg_sel <= s;
        fg_wdata <= d;
        @(posedge clk);
        fg_wr <= 1'h0;
        @(posedge clk);
    endtask
    // Exit service that points at one semaphore flag
    task automatic sem_point(input logic [4:0] p);
        fg_sem_wr <= 1'h1;
        fg_wdata <= {27'h000_0000, p};
        @(posedge clk);
        fg_sem_wr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic fg_read(input logic [2:0] s, output logic [31:0] d);
        fg_sel <= s;
        repeat (2) @(posedge clk);
        d = fg_rdata;
    endtask
endmodule

//--- verif/tb_vpc_regs.sv
// Self-checking testbench of the vector processor control registers
module tb_vpc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_n, proc_idle, monitor_mode, fg_wr, fg_sem_wr, ins_valid;
    logic ins_ready, ins_vec, ins_jump, vec_noop, elem_valid, vec_done;
    logic mem_quiet, sem_set, sem_clr, ref_valid, ref_write, ref_rvalid;
    logic mem_valid, mem_write, mem_rvalid;
    logic [1:0] ins_parcels;
    logic [2:0] fg_sel;
    logic [4:0] sem_sel;
    logic [5:0] elem_idx;
    logic [6:0] ins_op, vl_out;
    logic [31:0] fg_wdata, fg_rdata, ins_target, ins_ak, prog_addr, rd;
    logic [31:0] sem_flags, ref_addr, mem_addr, status;
    logic [63:0] ins_sj, rtc_out, ref_wdata, ref_rdata, mem_wdata;
    logic [63:0] mem_rdata, r1, r2;
    int n_mismatch, tests_run, c_set, c_clr, c_noop, c_done, c_elem, wcnt;

    vpc_regs u_vpc_regs (.clk, .rst_n, .proc_idle, .monitor_mode, .fg_wr,
        .fg_sem_wr, .fg_sel, .fg_wdata, .fg_rdata, .ins_valid, .ins_ready,
        .ins_op, .ins_vec, .ins_parcels, .ins_jump, .ins_target, .ins_ak,
        .ins_sj, .vl_out, .rtc_out, .prog_addr, .vec_noop, .elem_valid,
        .elem_idx, .vec_done, .sem_flags, .mem_quiet, .sem_sel, .sem_set,
        .sem_clr, .ref_valid, .ref_write, .ref_addr, .ref_wdata, .ref_rvalid,
        .ref_rdata, .mem_valid, .mem_write, .mem_addr, .mem_wdata,
        .mem_rvalid, .mem_rdata, .status);
    vpc_fg_model u_vpc_fg_model (.clk, .proc_idle, .fg_wr, .fg_sem_wr,
        .fg_sel, .fg_wdata, .fg_rdata);

    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    // Pulse and element counters
    always @(posedge clk) begin
        if (sem_set === 1'h1) c_set++;
        if (sem_clr === 1'h1) c_clr++;
        if (vec_noop === 1'h1) c_noop++;
        if (vec_done === 1'h1) c_done++;
        if (elem_valid === 1'h1) begin
            chk(elem_idx, c_elem[5:0]);
            c_elem++;
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic zero;
        c_set = 0;
        c_clr = 0;
        c_noop = 0;
        c_done = 0;
        c_elem = 0;
    endtask
    task automatic issue(input logic [6:0] op, input logic v,
        input logic [1:0] pc, input logic j, input logic [63:0] d);
        ins_op <= op;
        ins_vec <= v;
        ins_parcels <= pc;
        ins_jump <= j;
        ins_target <= d[31:0];
        ins_ak <= d[31:0];
        ins_sj <= d;
        ins_valid <= 1'h1;
        @(posedge clk);
        for (wcnt = 0; wcnt < 200 && ins_ready !== 1'h1; wcnt++)
            @(posedge clk);
        if (wcnt >= 200) n_mismatch++;
        ins_valid <= 1'h0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        for (int i = 0; i < 7; i++) begin
            u_vpc_fg_model.fg_read(i[2:0], rd);
            if (i != 1) chk(rd, 32'h0000_0000);
        end
        u_vpc_fg_model.fg_read(vpc_pkg::SEL_RTC_LO, r1[31:0]);
        u_vpc_fg_model.fg_read(vpc_pkg::SEL_RTC_LO, r2[31:0]);
        chk(r2[31:0] - r1[31:0], 32'h0000_0002);
    endtask
    task automatic t_regs;
        u_vpc_fg_model.fg_write(vpc_pkg::SEL_BASE, 32'h0000_0100);
        u_vpc_fg_model.fg_write(vpc_pkg::SEL_LIMIT, 32'h0000_1000);
        u_vpc_fg_model.fg_write(vpc_pkg::SEL_PROG, 32'h0000_0020);
        u_vpc_fg_model.set_idle(1'h0);
        u_vpc_fg_model.fg_write(vpc_pkg::SEL_BASE, 32'h0000_0bad);
        u_vpc_fg_model.fg_write(vpc_pkg::SEL_LIMIT, 32'h0000_0000);
        u_vpc_fg_model.fg_read(vpc_pkg::SEL_BASE, rd);
        chk(rd, 32'h0000_0100);
        u_vpc_fg_model.fg_read(vpc_pkg::SEL_LIMIT, rd);
        chk(rd, 32'h0000_1000);
    endtask
    task automatic load_rtc(input logic [63:0] d, output logic [63:0] r);
        issue(vpc_pkg::OP_S_TO_RTC, 1'h0, 2'h0, 1'h0, d);
        issue(vpc_pkg::OP_RTC_TO_S, 1'h0, 2'h0, 1'h0, 64'h0);
        @(posedge clk);
        r = rtc_out;
    endtask
    task automatic t_rtc;
        monitor_mode <= 1'h0;
        load_rtc(64'hff00_0000_0000_0000, r1);
        chk(r1[63:32], 32'h0000_0000);
        monitor_mode <= 1'h1;
        load_rtc(64'h0000_00a5_0000_0004, r1);
        load_rtc(64'h0000_00a5_0000_0007, r2);
        chk(r1[63:32], 32'h0000_00a5);
        chk(r1[31:0] < 32'h0000_0010, 1'h1);
        chk(r2, r1);
    endtask
    task automatic t_vec(input logic [31:0] ak, input logic [6:0] op,
        input int n, input int nop);
        issue(vpc_pkg::OP_A_TO_VL, 1'h0, 2'h0, 1'h0, {32'h0, ak});
        issue(vpc_pkg::OP_VL_TO_A, 1'h0, 2'h0, 1'h0, 64'h0);
        @(posedge clk);
        chk(vl_out, ak[6:0]);
        zero();
        issue(op, 1'h1, 2'h0, 1'h0, 64'h0);
        for (int i = 0; i < 100 && c_done + c_noop == 0; i++)
            @(posedge clk);
        chk(c_elem, n);
        chk(c_noop, nop);
        chk(c_done + c_noop, 1);
    endtask
    task automatic t_prog;
        u_vpc_fg_model.set_idle(1'h1);
        u_vpc_fg_model.fg_write(vpc_pkg::SEL_PROG, 32'h0000_0020);
        u_vpc_fg_model.set_idle(1'h0);
        issue(7'h0a, 1'h0, 2'h0, 1'h0, 64'h0);
        issue(7'h2a, 1'h0, 2'h2, 1'h0, 64'h0);
        chk(wcnt, 0);
        @(posedge clk);
        chk(prog_addr, 32'h0000_0024);
        issue(7'h03, 1'h0, 2'h2, 1'h1, 64'h0000_0300);
        @(posedge clk);
        u_vpc_fg_model.fg_read(vpc_pkg::SEL_PROG, rd);
        chk(rd, 32'h0000_0300);
    endtask
    task automatic t_ref(input logic w, input logic [31:0] a, input logic ok);
        ref_valid <= 1'h1;
        ref_write <= w;
        ref_addr <= a;
        ref_wdata <= 64'h0123_4567_89ab_cdef;
        @(posedge clk);
        ref_valid <= 1'h0;
        @(posedge clk);
        chk(mem_valid, ok);
        if (ok) chk({mem_addr, mem_write}, {a + 32'h0000_0100, w});
        if (ok && w) chk(mem_wdata, 64'h0123_4567_89ab_cdef);
        if (ok && !w) begin
            mem_rvalid <= 1'h1;
            mem_rdata <= 64'h0000_1111_2222_3333;
            @(posedge clk);
            mem_rvalid <= 1'h0;
        end
        @(posedge clk);
        if (!w) chk({ref_rvalid, ref_rdata},
            {1'h1, ok ? 64'h0000_1111_2222_3333 : 64'h0});
    endtask
    task automatic t_mem;
        t_ref(1'h1, 32'h0000_0010, 1'h1);
        t_ref(1'h0, 32'h0000_0eff, 1'h1);
        t_ref(1'h1, 32'h0000_0f00, 1'h0);
        u_vpc_fg_model.fg_read(vpc_pkg::SEL_STATUS, rd);
        chk(rd[14:13], 2'h2);
        u_vpc_fg_model.fg_write(vpc_pkg::SEL_STATUS, 32'h0000_0000);
        t_ref(1'h0, 32'h0000_0f00, 1'h0);
        u_vpc_fg_model.fg_read(vpc_pkg::SEL_STATUS, rd);
        chk(rd[14:13], 2'h1);
        chk(status[14:13], 2'h1);
    endtask
    task automatic t_sem;
        u_vpc_fg_model.sem_point(5'h05);
        u_vpc_fg_model.fg_read(vpc_pkg::SEL_STATUS, rd);
        chk({sem_sel, rd[4:0]}, 10'h0a5);
        zero();
        issue(vpc_pkg::OP_JCS, 1'h0, 2'h2, 1'h0, 64'h0000_0400);
        @(posedge clk);
        chk(prog_addr, 32'h0000_0400);
        sem_flags <= 32'h0000_0020;
        issue(vpc_pkg::OP_JCS, 1'h0, 2'h2, 1'h0, 64'h0000_0500);
        @(posedge clk);
        chk(prog_addr, 32'h0000_0403);
        issue(vpc_pkg::OP_JSS, 1'h0, 2'h2, 1'h0, 64'h0000_0600);
        @(posedge clk);
        chk(prog_addr, 32'h0000_0600);
        issue(vpc_pkg::OP_SSM, 1'h0, 2'h0, 1'h0, 64'h0);
        mem_quiet <= 1'h0;
        issue(vpc_pkg::OP_CSM, 1'h0, 2'h0, 1'h0, 64'h0);
        repeat (4) @(posedge clk);
        chk({c_set, c_clr}, {32'h4, 32'h0});
        mem_quiet <= 1'h1;
        repeat (4) @(posedge clk);
        chk(c_clr, 1);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        {rst_n, monitor_mode, ins_valid, ins_vec, ins_jump} = 5'h00;
        {ref_valid, ref_write, mem_rvalid, mem_quiet} = 4'h1;
        {ins_op, ins_parcels, ins_target, ins_ak, sem_flags} = '0;
        {ins_sj, ref_addr, ref_wdata} = '0;
        mem_rdata = 64'hdead_beef_dead_beef;
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_rtc();
        t_vec(32'hffff_ffc5, 7'h38, 64, 0);
        t_vec(32'h0000_0003, 7'h38, 3, 0);
        t_vec(32'h0000_0080, 7'h38, 0, 1);
        for (int op = 24; op < 28; op++) t_vec(32'h0, op[6:0], 0, 0);
        t_prog();
        t_mem();
        t_sem();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
